/* File: hw/adc_serial_device.sv */
// Converter end: conversion cycle, sleep, serial data cycle and settings.
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_map.svh"

//////////////////////////////////////////////////////////////////////////////
module adc_serial_device
	import adc_serial_pkg::*;
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Serial link.
	adc_serial_if.device link,
	// Converter core.
	input wire logic [`RESULT_BITS-1:0] i_sample,
	output logic o_conv_start,
	output logic o_conv_reversed,
	output logic o_temp_input,
	output logic [4:0] o_mux_channel,
	output logic [1:0] o_reject_mode,
	output logic [8:0] o_gain,
	output logic o_speed_double,
	// Status.
	output logic o_ext_mode,
	output logic o_eoc_n
);

	typedef struct packed {
		dev_state_t state;
		logic [1:0] settle;
		logic ext_mode;
		logic [2:0] sck_sy;
		logic [2:0] cs_sy;
		logic [1:0] sdi_sy;
		logic [15:0] tmr;
		logic phase;
		logic [`RESULT_BITS-1:0] first;
		logic [`OUT_WORD_BITS-1:0] shift;
		logic [`IN_WORD_BITS-1:0] in_word;
		logic [7:0] head_byte;
		logic [`IN_WORD_BITS-1:0] full_word;
		logic [4:0] falls;
		logic [4:0] channel;
		logic [6:0] config_bits;
		logic [8:0] gain;
		logic sdo;
		logic conv_start;
	} dev_regs_t;

	dev_regs_t r_q;
	dev_regs_t r_d;

	//////////////////////////////////////////////////////////////////////////
	// Gain decode: normal speed skips gain 2, double speed tops out at 128.
	function automatic logic [8:0] gain_value(input logic speed2x, input logic [2:0] sel);
		logic [8:0] g;
		g = 9'h001;
		if (speed2x) begin
			g = 9'h001 << sel;
		end else if (sel != 3'h0) begin
			g = 9'h001 << ({1'b0, sel} + 4'h1);
		end
		return g;
	endfunction

	// Double speed is honoured only for external inputs.
	function automatic logic speed_eff(input logic [6:0] cfg);
		return cfg[`CFG_SPEED_BIT] & ~cfg[`CFG_TEMP_BIT];
	endfunction

	//////////////////////////////////////////////////////////////////////////
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic cs_fall;
	logic [4:0] falls_next;
	logic [`OUT_WORD_BITS-1:0] diff;

	assign sck_rise = r_q.sck_sy[1] & ~r_q.sck_sy[2];
	assign sck_fall = ~r_q.sck_sy[1] & r_q.sck_sy[2];
	assign cs_rise = r_q.cs_sy[1] & ~r_q.cs_sy[2];
	assign cs_fall = ~r_q.cs_sy[1] & r_q.cs_sy[2];
	assign falls_next = r_q.falls + 5'd1;
	assign diff = {r_q.first[`RESULT_BITS-1], r_q.first} - {i_sample[`RESULT_BITS-1], i_sample};

	always_comb begin
		r_d = r_q;
		r_d.conv_start = 1'b0;
		r_d.sck_sy = {r_q.sck_sy[1:0], link.sck};
		r_d.cs_sy = {r_q.cs_sy[1:0], link.cs_n};
		r_d.sdi_sy = {r_q.sdi_sy[0], link.sdi};

		// The clock mode is caught once the synchroniser holds real pin levels.
		if (r_q.settle != 2'd3) begin
			r_d.settle = r_q.settle + 2'd1;
		end
		if (r_q.settle == `MODE_SETTLE) begin
			r_d.ext_mode = ~r_q.sck_sy[1];
		end
		if (cs_fall) begin
			r_d.ext_mode = ~r_q.sck_sy[1];
		end

		case (r_q.state)
			DEV_CONVERT: begin
				r_d.sdo = 1'b1;
				if (r_q.tmr != 16'h0) begin
					r_d.tmr = r_q.tmr - 16'h1;
				end else if (!speed_eff(r_q.config_bits) && !r_q.phase) begin
					// Second half runs with the inputs swapped so the offset cancels.
					r_d.first = i_sample;
					r_d.phase = 1'b1;
					r_d.tmr = `CONV_PHASE_CYCLES - 16'h1;
					r_d.conv_start = 1'b1;
				end else begin
					if (speed_eff(r_q.config_bits)) begin
						r_d.shift = {1'b0, i_sample};
					end else begin
						r_d.shift = {1'b0, diff[`OUT_WORD_BITS-1:1]};
					end
					r_d.phase = 1'b0;
					r_d.sdo = 1'b0;
					r_d.state = DEV_SLEEP;
				end
			end
			DEV_SLEEP: begin
				r_d.sdo = r_q.shift[`OUT_WORD_BITS-1];
				if (sck_rise && !r_q.cs_sy[1] && r_q.ext_mode) begin
					r_d.in_word = {r_q.in_word[`IN_WORD_BITS-2:0], r_q.sdi_sy[1]};
					r_d.falls = 5'd0;
					r_d.state = DEV_DATA;
				end
			end
			DEV_DATA: begin
				// A fall that arrives with the CS rise still counts, since a host cuts on a fall.
				if (sck_rise) begin
					r_d.in_word = {r_q.in_word[`IN_WORD_BITS-2:0], r_q.sdi_sy[1]};
				end else if (sck_fall) begin
					r_d.falls = falls_next;
					if (falls_next == `FALL_CHANNEL) begin
						r_d.head_byte = r_q.in_word[7:0];
					end
					if (falls_next == `FALL_CONFIG) begin
						r_d.full_word = r_q.in_word;
					end
					if (falls_next == `FALL_LAST) begin
						r_d.state = DEV_CONVERT;
					end else begin
						r_d.shift = {r_q.shift[`OUT_WORD_BITS-2:0], 1'b0};
						r_d.sdo = r_q.shift[`OUT_WORD_BITS-2];
					end
				end
				if (cs_rise) begin
					r_d.state = DEV_CONVERT;
				end
			end
			default: begin
				r_d.state = DEV_CONVERT;
			end
		endcase

		// Settings change only when a conversion starts, so none lands mid-cycle.
		if (r_q.state == DEV_DATA && r_d.state == DEV_CONVERT) begin
			if (r_d.falls >= `FALL_CHANNEL && r_d.head_byte[7:5] == `ENABLE_PATTERN) begin
				r_d.channel = r_d.head_byte[4:0];
			end
			if (r_d.falls >= `FALL_CONFIG && r_d.full_word[15:13] == `ENABLE_PATTERN &&
				r_d.full_word[`CFG_EN_BIT]) begin
				r_d.config_bits = r_d.full_word[6:0];
			end
			r_d.tmr = `CONV_PHASE_CYCLES - 16'h1;
			r_d.phase = 1'b0;
			r_d.conv_start = 1'b1;
			r_d.sdo = 1'b1;
		end
		r_d.gain = gain_value(speed_eff(r_d.config_bits), r_d.config_bits[2:0]);
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r_q <= '{state: DEV_CONVERT, tmr: `CONV_PHASE_CYCLES - 16'h1,
				sck_sy: 3'b000, cs_sy: 3'b111, sdo: 1'b1, ext_mode: 1'b1,
				channel: `CHANNEL_RESET, config_bits: `CONFIG_RESET, gain: 9'h001,
				default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// The pin is released a couple of cycles after CS rises, a cost of synchronising.
	assign link.sdo = r_q.sdo;
	assign link.sdo_oe = ~r_q.cs_sy[1];
	assign o_conv_start = r_q.conv_start;
	assign o_conv_reversed = r_q.phase;
	assign o_temp_input = r_q.config_bits[`CFG_TEMP_BIT];
	assign o_mux_channel = r_q.channel;
	assign o_reject_mode = r_q.config_bits[5:4];
	assign o_gain = r_q.gain;
	assign o_speed_double = speed_eff(r_q.config_bits);
	assign o_ext_mode = r_q.ext_mode;
	assign o_eoc_n = (r_q.state == DEV_CONVERT);

endmodule

`default_nettype wire

/* File: hw/adc_serial_host.sv */
// Host end: Avalon-MM register slave that runs data cycles on the serial link.
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_map.svh"

module adc_serial_host
	import adc_serial_pkg::*;
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Avalon-MM slave.
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Serial link.
	adc_serial_if.host link
);

	typedef struct packed {
		host_state_t state;
		logic [7:0] div;
		logic sck;
		logic cs_n;
		logic [1:0] sdo_sy;
		logic [15:0] tx;
		logic [23:0] rx;
		logic [23:0] result;
		logic [4:0] falls;
		logic [4:0] nfalls;
		logic hold;
		logic ack;
		logic [31:0] rdata;
	} host_regs_t;

	host_regs_t r_q;
	host_regs_t r_d;
	logic req;

	assign req = i_avs_read | i_avs_write;

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_d = r_q;
		r_d.sdo_sy = {r_q.sdo_sy[0], link.sdo_line};
		r_d.ack = req & ~r_q.ack;
		if (req && !r_q.ack) begin
			case (i_avs_address)
				`REG_CTRL: r_d.rdata = {15'h0, r_q.hold, 3'h0, r_q.nfalls, 8'h0};
				`REG_TXWORD: r_d.rdata = {16'h0, r_q.tx};
				`REG_STATUS: r_d.rdata = {29'h0, r_q.cs_n, r_q.sdo_sy[1],
					r_q.state != HOST_IDLE};
				`REG_RESULT: r_d.rdata = {8'h0, r_q.result};
				default: r_d.rdata = 32'h0;
			endcase
		end
		if (i_avs_write && r_q.ack && r_q.state == HOST_IDLE) begin
			if (i_avs_address == `REG_TXWORD) begin
				r_d.tx = i_avs_writedata[15:0];
			end
			if (i_avs_address == `REG_CTRL) begin
				r_d.hold = i_avs_writedata[`CTRL_HOLD_BIT];
				r_d.nfalls = i_avs_writedata[12:8];
				if (r_d.nfalls == 5'd0 || r_d.nfalls > `FALL_LAST) begin
					r_d.nfalls = `FALL_LAST;
				end
				if (i_avs_writedata[`CTRL_GO_BIT]) begin
					// SCK stays low as CS falls to keep the external clock mode.
					r_d.cs_n = 1'b0;
					r_d.sck = 1'b0;
					r_d.falls = 5'd0;
					r_d.div = `HOST_SCK_HALF;
					r_d.state = HOST_WAIT;
				end
			end
		end

		case (r_q.state)
			HOST_IDLE: begin
			end
			HOST_WAIT: begin
				if (r_q.div != 8'h0) begin
					r_d.div = r_q.div - 8'h1;
				end else if (!r_q.sdo_sy[1]) begin
					r_d.sck = 1'b1;
					r_d.rx = {r_q.rx[22:0], r_q.sdo_sy[1]};
					r_d.div = `HOST_SCK_HALF;
					r_d.state = HOST_HIGH;
				end
			end
			HOST_HIGH: begin
				if (r_q.div != 8'h0) begin
					r_d.div = r_q.div - 8'h1;
				end else begin
					r_d.sck = 1'b0;
					r_d.falls = r_q.falls + 5'd1;
					r_d.tx = {r_q.tx[14:0], 1'b0};
					r_d.div = `HOST_SCK_HALF;
					r_d.state = HOST_LOW;
					if (r_d.falls == r_q.nfalls) begin
						// Short counts raise CS early and abort the transfer.
						r_d.cs_n = ~(r_q.hold && r_q.nfalls == `FALL_LAST);
						r_d.result = r_q.rx;
						r_d.state = HOST_IDLE;
					end
				end
			end
			HOST_LOW: begin
				if (r_q.div != 8'h0) begin
					r_d.div = r_q.div - 8'h1;
				end else begin
					r_d.sck = 1'b1;
					r_d.rx = {r_q.rx[22:0], r_q.sdo_sy[1]};
					r_d.div = `HOST_SCK_HALF;
					r_d.state = HOST_HIGH;
				end
			end
			default: begin
				r_d.state = HOST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r_q <= '{state: HOST_IDLE, cs_n: 1'b1, sdo_sy: 2'b11, nfalls: `FALL_LAST,
				default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	assign link.sck = r_q.sck;
	assign link.cs_n = r_q.cs_n;
	assign link.sdi = r_q.tx[15];
	assign o_avs_readdata = r_q.rdata;
	assign o_avs_waitrequest = req & ~r_q.ack;

endmodule

`default_nettype wire

/* File: hw/adc_serial_if.sv */
// Four-wire serial link between the converter and its host controller.
`timescale 1ns/1ps
`default_nettype none

interface adc_serial_if;
	logic sck;
	logic cs_n;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	// Released output reads high, as a weak pull-up would give it.
	wire sdo_line;

	assign sdo_line = sdo_oe ? sdo : 1'b1;

	modport device (input sck, input cs_n, input sdi, output sdo, output sdo_oe);
	modport host (output sck, output cs_n, output sdi, input sdo_line);
endinterface

`default_nettype wire

/* File: hw/adc_serial_map.svh */
// Offsets, field positions, reset values and timing counts of the serial converter link.
`ifndef ADC_SERIAL_MAP_SVH
`define ADC_SERIAL_MAP_SVH

`define SYS_CLK_MHZ 200
`define IN_WORD_BITS 16
`define OUT_WORD_BITS 24
`define RESULT_BITS 23
`define ENABLE_PATTERN 3'b101
`define FALL_CHANNEL 5'd8
`define FALL_CONFIG 5'd16
`define FALL_LAST 5'd24
`define CFG_EN_BIT 7
`define CFG_TEMP_BIT 6
`define CFG_SPEED_BIT 3
`define CHANNEL_RESET 5'h00
`define CONFIG_RESET 7'h00
`define CONV_PHASE_CYCLES 16'd256
`define MODE_SETTLE 2'd2
`define HOST_SCK_HALF 8'd8
`define REG_CTRL 4'h0
`define REG_TXWORD 4'h4
`define REG_STATUS 4'h8
`define REG_RESULT 4'hc
`define CTRL_GO_BIT 0
`define CTRL_HOLD_BIT 16

`endif

/* File: hw/adc_serial_pkg.sv */
// Types shared by both ends of the serial converter link.
package adc_serial_pkg;

	typedef enum logic [2:0] {
		DEV_CONVERT = 3'b001,
		DEV_SLEEP = 3'b010,
		DEV_DATA = 3'b100
	} dev_state_t;

	typedef enum logic [3:0] {
		HOST_IDLE = 4'b0001,
		HOST_WAIT = 4'b0010,
		HOST_HIGH = 4'b0100,
		HOST_LOW = 4'b1000
	} host_state_t;

endpackage

/* File: verification/adc_serial_conversion_ctrl_asserts.sv */
// Checker for the wires between converter and host.
`timescale 1ns/1ps
`default_nettype none

module adc_link_asserts (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Link wires.
	input wire logic sck,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic sdo_line
);
	typedef struct packed {
		logic sck;
		logic [4:0] falls;
	} mon_t;
	mon_t mon_q;
	mon_t mon_d;
	logic last_fall;

	////////////////////////////////////////
	// Falls are counted at the pins, before the device's synchroniser delay.
	always_comb begin
		mon_d = mon_q;
		mon_d.sck = sck;
		if (cs_n) begin
			mon_d.falls = 5'h00;
		end else if (mon_q.sck && !sck) begin
			// The count wraps after a full frame so frames under a held select count too.
			mon_d.falls = (mon_q.falls == 5'h18) ? 5'h01 : mon_q.falls + 5'h01;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mon_q <= '0;
		end else begin
			mon_q <= mon_d;
		end
	end

	assign last_fall = mon_q.sck && !sck && !cs_n && mon_q.falls == 5'h17;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	oe_release_a: assert property (cs_n [*4] |-> !sdo_oe)
		else $error("sdo driven while deselected");
	oe_drive_a: assert property (!cs_n [*4] |-> sdo_oe)
		else $error("sdo released while selected");
	sck_low_a: assert property ($fell(cs_n) |-> !sck)
		else $error("sck high at select");
	sdo_steady_a: assert property ((!cs_n && sck) [*5] |-> $stable(sdo))
		else $error("sdo moved while sck high");
	sdi_steady_a: assert property (!cs_n && sck && $past(sck) |-> $stable(sdi))
		else $error("sdi moved while sck high");
	new_conv_a: assert property (last_fall |-> ##[1:6] sdo_line)
		else $error("no busy flag after last fall");
	busy_flag_a: assert property (last_fall |-> ##6 sdo_line [*8])
		else $error("busy flag dropped early");
	sleep_hold_a: assert property (!cs_n && sdo_oe && !sdo && mon_q.falls == 5'h00 && !sck
		|=> !sdo || cs_n || sck)
		else $error("sleep left without sck");
endmodule

`default_nettype wire

/* File: verification/test_adc_serial_conversion_ctrl.sv */
// Bench joining converter and host ends over the serial link.
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_map.svh"

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) err(n, e, g); end

module test_adc_serial_conversion_ctrl;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] av_addr = 4'h0;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wd = 32'h0;
	logic [31:0] av_rdata;
	logic av_wait;
	logic [31:0] rdat;
	logic [22:0] samp = 23'h012345;
	logic [22:0] exp_res = 23'h012345;
	logic rev, temp, speed_double, ext, eoc_n, cstart;
	logic [4:0] chan;
	logic [1:0] rej;
	logic [8:0] gain;
	int fails = 0;
	int checks = 0;

	adc_serial_if link();

	always #2.5 sys_clk = ~sys_clk;

	// The core model swaps sign in the reversed phase, so both speeds yield samp.
	adc_serial_device u_adc_serial_device (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
		.link(link), .i_sample(rev ? 23'h0 - samp : samp), .o_conv_start(cstart),
		.o_conv_reversed(rev), .o_temp_input(temp), .o_mux_channel(chan),
		.o_reject_mode(rej), .o_gain(gain), .o_speed_double(speed_double), .o_ext_mode(ext),
		.o_eoc_n(eoc_n));
	adc_serial_host u_adc_serial_host (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
		.i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
		.i_avs_writedata(av_wd), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
		.link(link));
	adc_link_asserts u_adc_link_asserts (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
		.sck(link.sck), .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo),
		.sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));

	////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic err(input string n, input logic [31:0] e, input logic [31:0] g);
		fails++;
		$display("wrong value %s expected %0h seen %0h", n, e, g);
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		av_addr <= a;
		av_wd <= d;
		av_wr <= wr;
		av_rd <= !wr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (av_wait !== 1'b0 && n < 50);
		rdat = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		if (n >= 50) begin
			fails++;
			give_verdict();
		end
	endtask

	// Writes while the link is busy are dropped, so status is polled until the link is idle before returning.
	task automatic cycle(input logic [15:0] w, input logic [4:0] nf, input logic hold);
		int n;
		bus(1'b1, `REG_TXWORD, {16'h0, w});
		bus(1'b1, `REG_CTRL, {15'h0, hold, 3'h0, nf, 8'h01});
		n = 0;
		do begin
			bus(1'b0, `REG_STATUS, 32'h0);
			n++;
		end while (rdat[0] !== 1'b0 && n < 4000);
		if (n >= 4000) begin
			fails++;
			give_verdict();
		end
		repeat (10) @(posedge sys_clk);
	endtask

	task automatic next_res(input logic [22:0] v);
		bus(1'b0, `REG_RESULT, 32'h0);
		`CHK("result", {1'b0, exp_res}, rdat[23:0])
		samp <= v;
		exp_res = v;
	endtask

	function automatic logic [8:0] gx(input logic s, input logic [2:0] g);
		gx = s ? 9'h1 << g : (g == 3'h0 ? 9'h1 : 9'h1 << ({1'b0, g} + 4'h1));
	endfunction

	////////////////////////////////////////
	task automatic t_loop;
		for (int i = 0; i < 16; i++) begin
			cycle({3'b101, i[4:0], 2'b10, 2'(i % 3), i[3], i[2:0]}, 5'd24, 1'b0);
			`CHK("chan", i[4:0], chan)
			`CHK("gain", gx(i[3], i[2:0]), gain)
			`CHK("speed", i[3], speed_double)
			`CHK("reject", 2'(i % 3), rej)
			next_res({7'h0, i[3:0], 12'hab3});
		end
	endtask

	task automatic t_abort;
		cycle({3'b101, 5'h07, 8'h80}, 5'd4, 1'b0);
		`CHK("chan", 5'h0f, chan)
		samp <= 23'h00abcd;
		cycle({3'b101, 5'h09, 8'h80}, 5'd12, 1'b0);
		`CHK("chan", 5'h09, chan)
		`CHK("gain", 9'h080, gain)
		exp_res = 23'h00abcd;
		cycle({3'b101, 5'h0a, 8'h00}, 5'd24, 1'b0);
		`CHK("chan", 5'h0a, chan)
		`CHK("speed", 1'b1, speed_double)
		next_res(23'h004321);
		cycle({3'b101, 5'h0c, 8'h82}, 5'd8, 1'b0);
		`CHK("chan", 5'h0c, chan)
		`CHK("speed", 1'b1, speed_double)
		cycle({3'b101, 5'h0b, 8'h82}, 5'd16, 1'b0);
		`CHK("chan", 5'h0b, chan)
		`CHK("gain", 9'h008, gain)
		`CHK("speed", 1'b0, speed_double)
	endtask

	task automatic t_rate(input logic [7:0] cfg, input int lo, input int hi, input logic er,
		input logic et);
		int n;
		int pulses;
		logic seen;
		cycle({3'b101, 5'h03, cfg}, 5'd24, 1'b1);
		n = 0;
		pulses = 0;
		seen = 1'b0;
		`CHK("eoc busy", 1'b1, eoc_n)
		while (link.sdo_line !== 1'b0 && n < 2000) begin
			@(posedge sys_clk);
			seen |= rev;
			pulses += (cstart === 1'b1) ? 1 : 0;
			n++;
		end
		if (n >= 2000) begin
			fails++;
			give_verdict();
		end
		`CHK("conv time", 1'b1, n > lo && n < hi)
		`CHK("two phases", er, seen)
		`CHK("phase starts", {31'h0, er}, pulses)
		`CHK("eoc done", 1'b0, eoc_n)
		`CHK("temp", et, temp)
		`CHK("speed", cfg[3] & !et, speed_double)
		`CHK("chan", 5'h03, chan)
		next_res(samp);
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		`CHK("ext mode", 1'b1, ext)
		`CHK("oe idle", 1'b0, link.sdo_oe)
		`CHK("gain", 9'h001, gain)
		t_loop();
		t_abort();
		t_rate(8'h80, 400, 600, 1'b1, 1'b0);
		t_rate(8'h88, 150, 300, 1'b0, 1'b0);
		t_rate(8'hc8, 400, 600, 1'b1, 1'b1);
		give_verdict();
	end
endmodule

`default_nettype wire
